// [shared/sltsr_regs.svh]
`ifndef SLTSR_REGS_SVH
`define SLTSR_REGS_SVH
// register indices; byte address is four times the index
`define SLTSR_IDX_LINK_EN   12'h200
`define SLTSR_IDX_TEST      12'h205
`define SLTSR_IDX_IDENT     12'h206
`define SLTSR_IDX_COMMA     12'h207
`define SLTSR_IDX_STATUS    12'h208
`define SLTSR_IDX_IRQ_STAT  12'h210
`define SLTSR_IDX_IRQ_MASK  12'h211
// field positions in the status register
`define SLTSR_ST_LINK_UP    6
`define SLTSR_ST_SYNC       5
`define SLTSR_ST_REALIGN    4
`define SLTSR_ST_MULTIFRAME_PHASE_SET_FLAG    3
`define SLTSR_ST_PLL        2
// reset values
`define SLTSR_RST_LINK_EN   1'b1
`define SLTSR_RST_TEST      4'h0
`define SLTSR_RST_IDENT     8'h00
`define SLTSR_RST_COMMA     2'h0
`define SLTSR_RST_IRQ_MASK  4'h0
// characters
`define SLTSR_K28_0         8'h1c
`define SLTSR_K28_1         8'h3c
`define SLTSR_K28_3         8'h7c
`define SLTSR_K28_4         8'h9c
`define SLTSR_K28_5         8'hbc
`define SLTSR_K28_7         8'hfc
`define SLTSR_D21_5         8'hb5
`endif

// [shared/sltsr_pkg.sv]
package sltsr_pkg;
  // test pattern selector codes
  typedef enum logic [3:0] {
    SLTSR_TP_NORMAL = 4'h0, SLTSR_TP_PRBS7 = 4'h1, SLTSR_TP_PRBS15 = 4'h2,
    SLTSR_TP_PRBS23 = 4'h3, SLTSR_TP_RAMP  = 4'h4, SLTSR_TP_TRANSP = 4'h5,
    SLTSR_TP_D215   = 4'h6, SLTSR_TP_K285  = 4'h7, SLTSR_TP_ILA    = 4'h8,
    SLTSR_TP_RPAT   = 4'h9, SLTSR_TP_LOW   = 4'ha, SLTSR_TP_HIGH   = 4'hb
  } sltsr_tp_t;
  // one octet on a lane, before 8b/10b
  typedef struct packed {
    logic       is_k;
    logic [7:0] d;
  } sltsr_word_t;
  // apb request group
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } sltsr_apb_req_t;
endpackage

// [src/sltsr_top.sv]
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "sltsr_regs.svh"
module sltsr_top import sltsr_pkg::*; #(
  parameter int LANES   = 4,
  parameter int LMFC_LEN = 32,
  parameter int FRM_LEN  = 2
) (
  input  wire logic           ref_clk,
  input  wire logic           srst,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [15:0]    paddr,
  input  wire logic [31:0]    pwdata,
  output logic                pready,
  output logic [31:0]         prdata,
  output logic                pslverr,
  input  wire logic           sync_n_pin,
  input  wire logic           sysref_pin,
  input  wire logic           pll_lock_pin,
  input  wire logic           link_up,
  input  wire sltsr_word_t    conv_data,
  input  wire logic           conv_frame_end,
  output sltsr_word_t [2*LANES-1:0] lane_out,
  output logic                ser_force_en,
  output logic                ser_force_val,
  output logic                ser_pwr_dn,
  output logic                link_clk_en,
  output logic                lmfc_edge,
  output logic                irq
);
  localparam int LW = $clog2(LMFC_LEN);
  localparam int FW = $clog2(FRM_LEN) + 1;

  //////////////////////////////////////////////////////////////////
  // registers
  logic        link_en_ff;
  logic [3:0]  test_sel_ff;
  logic [7:0]  ident_ff;
  logic [1:0]  comma_sel_ff;
  logic        realign_ff;
  logic        multiframe_phase_set_flag_ff;
  logic        armed_ff;
  logic [3:0]  irq_stat_ff;
  logic [3:0]  irq_mask_ff;
  logic [31:0] prdata_ff;
  logic [2:0]  sync_sh_ff;
  logic [2:0]  sref_sh_ff;
  logic [2:0]  pll_sh_ff;
  logic        sync_n_q_ff;
  logic        sref_q_ff;
  logic        pll_q_ff;
  logic [LW-1:0] lmfc_ff;
  logic [1:0]  mf_ff;
  logic [22:0] prbs_ff;
  logic [7:0]  ramp_ff;
  logic [2:0]  rpat_ff;
  logic [FW-1:0] frm_ff;
  logic [7:0]  last_eof_ff;
  sltsr_word_t [2*LANES-1:0] lane_ff;

  //////////////////////////////////////////////////////////////////
  // bus decode
  function automatic logic hit(input logic [15:0] a, input logic [11:0] idx);
    hit = (a[15:2] == {2'h0, idx}) && (a[1:0] == 2'h0);
  endfunction

  wire        setup_ph = psel && !penable;
  wire        wr_acc   = psel && penable && pwrite;
  wire        h_en     = hit(paddr, `SLTSR_IDX_LINK_EN);
  wire        h_test   = hit(paddr, `SLTSR_IDX_TEST);
  wire        h_ident  = hit(paddr, `SLTSR_IDX_IDENT);
  wire        h_comma  = hit(paddr, `SLTSR_IDX_COMMA);
  wire        h_stat   = hit(paddr, `SLTSR_IDX_STATUS);
  wire        h_istat  = hit(paddr, `SLTSR_IDX_IRQ_STAT);
  wire        h_imask  = hit(paddr, `SLTSR_IDX_IRQ_MASK);
  wire        h_any    = h_en | h_test | h_ident | h_comma | h_stat | h_istat | h_imask;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !h_any;
  assign prdata  = prdata_ff;

  //////////////////////////////////////////////////////////////////
  // pin synchronisers: change taken once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync_sh_ff <= 3'h7;
      sref_sh_ff <= 3'h0;
      pll_sh_ff  <= 3'h0;
    end else begin
      sync_sh_ff <= {sync_sh_ff[1:0], sync_n_pin};
      sref_sh_ff <= {sref_sh_ff[1:0], sysref_pin};
      pll_sh_ff  <= {pll_sh_ff[1:0], pll_lock_pin};
    end
  end

  wire nxt_sync_n = (sync_sh_ff[1] == sync_sh_ff[2]) ? sync_sh_ff[2] : sync_n_q_ff;
  wire nxt_sref   = (sref_sh_ff[1] == sref_sh_ff[2]) ? sref_sh_ff[2] : sref_q_ff;
  wire nxt_pll    = (pll_sh_ff[1] == pll_sh_ff[2]) ? pll_sh_ff[2] : pll_q_ff;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync_n_q_ff <= 1'b1;
      sref_q_ff   <= 1'b0;
      pll_q_ff    <= 1'b0;
    end else begin
      sync_n_q_ff <= nxt_sync_n;
      sref_q_ff   <= nxt_sref;
      pll_q_ff    <= nxt_pll;
    end
  end

  //////////////////////////////////////////////////////////////////
  // sysref and multiframe clock; counter held while disabled
  wire sref_evt    = nxt_sref && !sref_q_ff && link_en_ff;
  wire lmfc_wrap   = (lmfc_ff == LW'(LMFC_LEN - 1));
  wire phase_shift = sref_evt && (lmfc_ff != '0);

  always_ff @(posedge ref_clk) begin
    if (srst || !link_en_ff) begin
      lmfc_ff <= '0;
      mf_ff   <= 2'h0;
    end else if (sref_evt) begin
      lmfc_ff <= '0;
      mf_ff   <= 2'h0;
    end else begin
      lmfc_ff <= lmfc_wrap ? '0 : lmfc_ff + 1'b1;
      mf_ff   <= lmfc_wrap ? mf_ff + 2'h1 : mf_ff;
    end
  end

  assign lmfc_edge   = link_en_ff && (lmfc_ff == '0);
  assign ser_pwr_dn  = !link_en_ff;
  assign link_clk_en = link_en_ff;

  //////////////////////////////////////////////////////////////////
  // sticky status flags; set wins over a write-one clear
  wire wr_stat   = wr_acc && h_stat;
  wire clr_rea   = wr_stat && pwdata[`SLTSR_ST_REALIGN];
  wire clr_ali   = wr_stat && pwdata[`SLTSR_ST_MULTIFRAME_PHASE_SET_FLAG];
  wire set_ali   = sref_evt && armed_ff;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      realign_ff <= 1'b0;
      multiframe_phase_set_flag_ff <= 1'b0;
      armed_ff   <= 1'b1;
    end else begin
      realign_ff <= phase_shift | (realign_ff & ~clr_rea);
      multiframe_phase_set_flag_ff <= set_ali | (multiframe_phase_set_flag_ff & ~clr_ali);
      armed_ff   <= link_en_ff ? (armed_ff & ~sref_evt) : 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////
  // interrupt: realign, multiframe_phase_set_flag, sync asserted, pll lock lost
  wire [3:0] irq_evt = {pll_q_ff & ~nxt_pll, sync_n_q_ff & ~nxt_sync_n, set_ali, phase_shift};
  wire [3:0] irq_clr = (wr_acc && h_istat) ? pwdata[3:0] : 4'h0;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_stat_ff <= 4'h0;
    end else begin
      irq_stat_ff <= irq_evt | (irq_stat_ff & ~irq_clr);
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  //////////////////////////////////////////////////////////////////
  // writable registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      link_en_ff   <= `SLTSR_RST_LINK_EN;
      test_sel_ff  <= `SLTSR_RST_TEST;
      ident_ff     <= `SLTSR_RST_IDENT;
      comma_sel_ff <= `SLTSR_RST_COMMA;
      irq_mask_ff  <= `SLTSR_RST_IRQ_MASK;
    end else if (wr_acc) begin
      if (h_en)    link_en_ff   <= pwdata[0];
      if (h_test)  test_sel_ff  <= pwdata[3:0];
      if (h_ident) ident_ff     <= {pwdata[7:1], 1'b0};
      if (h_comma) comma_sel_ff <= pwdata[1:0];
      if (h_imask) irq_mask_ff  <= pwdata[3:0];
    end
  end

  //////////////////////////////////////////////////////////////////
  // read data, latched in the setup phase
  wire [7:0] status_rd = {1'b0, link_up, sync_n_q_ff, realign_ff,
                          multiframe_phase_set_flag_ff, pll_q_ff, 2'b00};
  wire [7:0] rd_mux =
      h_en    ? {7'h00, link_en_ff} :
      h_test  ? {4'h0, test_sel_ff} :
      h_ident ? ident_ff :
      h_comma ? {6'h00, comma_sel_ff} :
      h_stat  ? status_rd :
      h_istat ? {4'h0, irq_stat_ff} :
      h_imask ? {4'h0, irq_mask_ff} : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata_ff <= 32'h0;
    end else if (setup_ph) begin
      prdata_ff <= {24'h0, rd_mux};
    end
  end

  //////////////////////////////////////////////////////////////////
  // pattern sources
  function automatic logic [30:0] prbs8(input logic [22:0] s, input logic [1:0] ord);
    logic [22:0] st;
    logic [7:0]  oct;
    logic        fb;
    st  = s;
    oct = 8'h00;
    for (int i = 0; i < 8; i++) begin
      fb  = (ord == 2'd1) ? (st[6] ^ st[5]) :
            (ord == 2'd2) ? (st[14] ^ st[13]) : (st[22] ^ st[17]);
      st  = {st[21:0], fb};
      oct = {oct[6:0], fb};
    end
    prbs8 = {st, oct};
  endfunction

  function automatic logic [7:0] comma_of(input logic [1:0] sel);
    case (sel)
      2'd1:    comma_of = `SLTSR_K28_1;
      2'd2:    comma_of = `SLTSR_K28_5;
      default: comma_of = `SLTSR_K28_7;
    endcase
  endfunction

  // short repeating jitter pattern table
  function automatic logic [7:0] rpat_of(input logic [2:0] i);
    case (i)
      3'd0:    rpat_of = 8'hbe;
      3'd1:    rpat_of = 8'hd7;
      3'd2:    rpat_of = 8'h23;
      3'd3:    rpat_of = 8'h47;
      3'd4:    rpat_of = 8'h6b;
      3'd5:    rpat_of = 8'h8f;
      3'd6:    rpat_of = 8'hb3;
      default: rpat_of = 8'h14;
    endcase
  endfunction

  wire [30:0] prbs_nxt  = prbs8(prbs_ff, test_sel_ff[1:0]);
  wire        frm_last  = conv_frame_end;
  wire        eof_repl  = frm_last && !conv_data.is_k && (conv_data.d == last_eof_ff);

  always_ff @(posedge ref_clk) begin
    if (srst || !link_en_ff) begin
      prbs_ff     <= 23'h7fffff;
      ramp_ff     <= 8'h00;
      rpat_ff     <= 3'h0;
      frm_ff      <= '0;
      last_eof_ff <= 8'h00;
    end else begin
      prbs_ff     <= prbs_nxt[30:8];
      ramp_ff     <= ramp_ff + 8'h01;
      rpat_ff     <= rpat_ff + 3'h1;
      frm_ff      <= (frm_ff == FW'(FRM_LEN - 1)) ? '0 : frm_ff + 1'b1;
      if (frm_last) last_eof_ff <= conv_data.d;
    end
  end

  //////////////////////////////////////////////////////////////////
  // per-lane octet selection; upper half of lanes is link B
  assign ser_force_en  = link_en_ff && ((test_sel_ff == SLTSR_TP_LOW) ||
                                        (test_sel_ff == SLTSR_TP_HIGH));
  assign ser_force_val = (test_sel_ff == SLTSR_TP_HIGH);

  for (genvar g = 0; g < 2 * LANES; g++) begin : g_lane
    wire [7:0]   lid   = (g >= LANES) ? ident_ff + 8'h01 : ident_ff;
    sltsr_word_t w_ila;
    sltsr_word_t w_sel;
    // initial lane alignment multiframes, identifier after /Q/
    always_comb begin
      w_ila = '{is_k: 1'b0, d: 8'h00};
      if (lmfc_ff == '0) begin
        w_ila = '{is_k: 1'b1, d: `SLTSR_K28_0};
      end else if (lmfc_wrap) begin
        w_ila = '{is_k: 1'b1, d: `SLTSR_K28_3};
      end else if (mf_ff == 2'd1 && lmfc_ff == LW'(1)) begin
        w_ila = '{is_k: 1'b1, d: `SLTSR_K28_4};
      end else if (mf_ff == 2'd1 && lmfc_ff == LW'(2)) begin
        w_ila = '{is_k: 1'b0, d: lid};
      end
    end
    always_comb begin
      case (test_sel_ff)
        SLTSR_TP_NORMAL: begin
          w_sel = eof_repl ? sltsr_word_t'{is_k: 1'b1, d: comma_of(comma_sel_ff)}
                           : conv_data;
        end
        SLTSR_TP_PRBS7, SLTSR_TP_PRBS15, SLTSR_TP_PRBS23: begin
          w_sel = '{is_k: 1'b0, d: prbs_nxt[7:0]};
        end
        SLTSR_TP_RAMP:   w_sel = '{is_k: 1'b0, d: ramp_ff};
        SLTSR_TP_TRANSP: w_sel = '{is_k: 1'b0, d: {4'(g), 4'(frm_ff)}};
        SLTSR_TP_D215:   w_sel = '{is_k: 1'b0, d: `SLTSR_D21_5};
        SLTSR_TP_K285:   w_sel = '{is_k: 1'b1, d: `SLTSR_K28_5};
        SLTSR_TP_ILA:    w_sel = w_ila;
        SLTSR_TP_RPAT:   w_sel = '{is_k: 1'b0, d: rpat_of(rpat_ff)};
        SLTSR_TP_LOW:    w_sel = '{is_k: 1'b0, d: 8'h00};
        SLTSR_TP_HIGH:   w_sel = '{is_k: 1'b0, d: 8'hff};
        default:         w_sel = '{is_k: 1'b0, d: 8'h00};
      endcase
    end
    always_ff @(posedge ref_clk) begin
      if (srst || !link_en_ff) begin
        lane_ff[g] <= '{is_k: 1'b0, d: 8'h00};
      end else begin
        lane_ff[g] <= w_sel;
      end
    end
  end

  assign lane_out = lane_ff;

  //////////////////////////////////////////////////////////////////
  // checks
  a_ident_even: assert property (@(posedge ref_clk) disable iff (srst)
    ident_ff[0] == 1'b0) else $error("identifier bit zero set");
  a_link_b_ident: assert property (@(posedge ref_clk) disable iff (srst)
    (link_en_ff && test_sel_ff == SLTSR_TP_ILA && mf_ff == 2'd1 && lmfc_ff == LW'(2)
     && $stable(test_sel_ff))
    |=> lane_out[LANES].d == lane_out[0].d + 8'h01) else $error("link b ident wrong");
  a_k285_lane: assert property (@(posedge ref_clk) disable iff (srst)
    (link_en_ff && test_sel_ff == SLTSR_TP_K285) [*2]
    |-> lane_out[0] == sltsr_word_t'{is_k: 1'b1, d: `SLTSR_K28_5}) else $error("k28.5 missing");
  a_force_high: assert property (@(posedge ref_clk) disable iff (srst)
    (link_en_ff && test_sel_ff == SLTSR_TP_HIGH) |-> ser_force_en && ser_force_val)
    else $error("outputs not forced high");
  a_realign_set: assert property (@(posedge ref_clk) disable iff (srst)
    phase_shift |=> realign_ff) else $error("realign flag not set");
  a_multiframe_phase_set_flag_first: assert property (@(posedge ref_clk) disable iff (srst)
    (sref_evt && armed_ff) |=> multiframe_phase_set_flag_ff && !armed_ff)
    else $error("multiframe_phase_set_flag flag missed first sysref");
  a_zero_write_keep: assert property (@(posedge ref_clk) disable iff (srst)
    (wr_stat && !pwdata[`SLTSR_ST_MULTIFRAME_PHASE_SET_FLAG]) |=> multiframe_phase_set_flag_ff == $past(multiframe_phase_set_flag_ff) || $past(set_ali))
    else $error("multiframe_phase_set_flag changed by zero write");
  a_sync_mirror: assert property (@(posedge ref_clk) disable iff (srst)
    (setup_ph && h_stat) |=> prdata[`SLTSR_ST_SYNC] == $past(sync_n_q_ff))
    else $error("sync status wrong");
  a_disabled_hold: assert property (@(posedge ref_clk) disable iff (srst)
    !link_en_ff |=> (lmfc_ff == '0) && (lane_out == '0))
    else $error("lmfc not held");
  a_pll_read: assert property (@(posedge ref_clk) disable iff (srst)
    (setup_ph && h_stat) |=> prdata[`SLTSR_ST_PLL] == $past(pll_q_ff))
    else $error("pll status wrong");
  a_comma_repl: assert property (@(posedge ref_clk) disable iff (srst)
    (link_en_ff && test_sel_ff == SLTSR_TP_NORMAL && eof_repl && comma_sel_ff == 2'd1)
    |=> lane_out[0] == sltsr_word_t'{is_k: 1'b1, d: `SLTSR_K28_1}) else $error("comma not inserted");

  c_ila_run:   cover property (@(posedge ref_clk) link_en_ff && test_sel_ff == SLTSR_TP_ILA
                               && mf_ff == 2'd3);
  c_realign:   cover property (@(posedge ref_clk) phase_shift);
  c_eof_repl:  cover property (@(posedge ref_clk) link_en_ff && eof_repl);
  c_irq:       cover property (@(posedge ref_clk) irq);
endmodule

// [test/sltsr_rx_model.sv]
`timescale 1ns/1ps
// receiver-side stand-in: answers with SYNC~ and link state, watches lanes
module sltsr_rx_model import sltsr_pkg::*; #(
  parameter int LANES = 4
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rx_ready,
  input  wire logic [7:0]                exp_ident,
  input  wire sltsr_word_t [2*LANES-1:0] lane_out,
  output logic                           sync_n_pin,
  output logic                           link_up,
  output logic                           seen_a,
  output logic                           seen_b
);
  ////////////////////////////////////////////////////////////////////////////
  // sync request held until the receiver is ready; link up one cycle later
  always @(posedge ref_clk) begin
    sync_n_pin <= rx_ready;
    link_up    <= rx_ready & sync_n_pin;
  end
  ////////////////////////////////////////////////////////////////////////////
  // identifier seen on the first lane of each link
  always @(posedge ref_clk) begin
    if (!rx_ready) begin
      seen_a <= 1'b0;
      seen_b <= 1'b0;
    end else begin
      if (lane_out[0] === {1'b0, exp_ident}) seen_a <= 1'b1;
      if (lane_out[LANES] === {1'b0, exp_ident + 8'h01}) seen_b <= 1'b1;
    end
  end
endmodule

// [test/testbench.sv]
`timescale 1ns/1ps
`include "sltsr_regs.svh"
module testbench import sltsr_pkg::*;;
  localparam int LANES = 4;
  logic ref_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, err, sysref_pin = 1'b0, pll_lock_pin = 1'b0;
  logic sync_n_pin, link_up, conv_frame_end = 1'b0, rx_ready = 1'b0;
  logic ser_force_en, ser_force_val, ser_pwr_dn, link_clk_en, lmfc_edge, irq;
  logic seen_a, seen_b, hold = 1'b0;
  logic [7:0] exp_ident = 8'h00;
  sltsr_word_t conv_data = 9'h000;
  sltsr_word_t [2*LANES-1:0] lane_out;
  int error_cnt = 0, cmp_count = 0, cyc = 0, n, i;
  int seed = 32'h75c9b9d0;
  int mdl[int];
  always #2.5 ref_clk = ~ref_clk;
  sltsr_top #(.LANES(LANES), .LMFC_LEN(8), .FRM_LEN(2)) i_sltsr_top (
    .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .sync_n_pin(sync_n_pin), .sysref_pin(sysref_pin),
    .pll_lock_pin(pll_lock_pin), .link_up(link_up), .conv_data(conv_data),
    .conv_frame_end(conv_frame_end), .lane_out(lane_out), .ser_force_en(ser_force_en),
    .ser_force_val(ser_force_val), .ser_pwr_dn(ser_pwr_dn), .link_clk_en(link_clk_en),
    .lmfc_edge(lmfc_edge), .irq(irq));
  sltsr_rx_model #(.LANES(LANES)) i_sltsr_rx_model (
    .ref_clk(ref_clk), .rx_ready(rx_ready), .exp_ident(exp_ident),
    .lane_out(lane_out), .sync_n_pin(sync_n_pin), .link_up(link_up),
    .seen_a(seen_a), .seen_b(seen_b));
  ////////////////////////////////////////////////////////////////////////////
  // random converter data and a hang limit
  always @(posedge ref_clk) begin
    conv_data      <= hold ? 9'h012 : 9'($random(seed));
    conv_frame_end <= ~conv_frame_end;
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // compare, bus transfer and model update
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00}; pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
    xfer(1'b1, idx, wd);
    case (idx)
      `SLTSR_IDX_IDENT: mdl[idx] = wd & 32'hfe;
      `SLTSR_IDX_COMMA: mdl[idx] = wd & 32'h3;
      `SLTSR_IDX_TEST: mdl[idx] = wd & 32'hf;
      `SLTSR_IDX_LINK_EN: mdl[idx] = wd & 32'h1;
      `SLTSR_IDX_IRQ_MASK: mdl[idx] = wd & 32'hf;
      default: ;
    endcase
  endtask
  task automatic rdc(input logic [11:0] idx);
    xfer(1'b0, idx, 32'h0);
    chk(rdv, mdl[idx]);
  endtask
  task automatic sysref_pulse();
    sysref_pin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sysref_pin <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    mdl[`SLTSR_IDX_LINK_EN] = 1; mdl[`SLTSR_IDX_TEST] = 0; mdl[`SLTSR_IDX_IDENT] = 0;
    mdl[`SLTSR_IDX_COMMA] = 0; mdl[`SLTSR_IDX_IRQ_MASK] = 0;
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    foreach (mdl[k]) rdc(k[11:0]);
    xfer(1'b0, 12'h3ff, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rdv, 32'h0);
    tend("reset");
    wr(`SLTSR_IDX_LINK_EN, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk({ser_pwr_dn, link_clk_en}, 32'h2);
    chk(32'(lane_out), 32'h0);
    for (i = 0; i < 4; i++) begin
      wr(`SLTSR_IDX_IDENT, 32'($random(seed)) | 32'h1);
      rdc(`SLTSR_IDX_IDENT);
    end
    for (i = 2; i >= 0; i--) begin
      wr(`SLTSR_IDX_COMMA, i);
      rdc(`SLTSR_IDX_COMMA);
    end
    for (i = 0; i < 12; i++) begin
      wr(`SLTSR_IDX_TEST, i);
      rdc(`SLTSR_IDX_TEST);
    end
    tend("fields");
    for (i = 10; i < 12; i++) begin
      wr(`SLTSR_IDX_TEST, i);
      wr(`SLTSR_IDX_LINK_EN, 32'h1);
      @(negedge ref_clk);
      chk({ser_force_en, ser_force_val}, {30'h0, 1'b1, i == 11});
      wr(`SLTSR_IDX_LINK_EN, 32'h0);
    end
    rx_ready <= 1'b1;
    for (i = 6; i < 8; i++) begin
      wr(`SLTSR_IDX_TEST, i);
      wr(`SLTSR_IDX_LINK_EN, 32'h1);
      repeat (4) @(posedge ref_clk);
      for (n = 0; n < 2 * LANES; n++)
        chk(32'(lane_out[n]), i == 6 ? {1'b0, `SLTSR_D21_5} : {1'b1, `SLTSR_K28_5});
      wr(`SLTSR_IDX_LINK_EN, 32'h0);
    end
    exp_ident <= 8'h5a;
    wr(`SLTSR_IDX_IDENT, 32'h5b);
    wr(`SLTSR_IDX_TEST, 32'h8);
    wr(`SLTSR_IDX_LINK_EN, 32'h1);
    repeat (200) @(posedge ref_clk);
    chk({seen_a, seen_b}, 32'h3);
    tend("patterns");
    pll_lock_pin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    xfer(1'b0, `SLTSR_IDX_STATUS, 32'h0);
    chk(rdv & 32'h64, 32'h64);
    rx_ready <= 1'b0;
    pll_lock_pin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    xfer(1'b0, `SLTSR_IDX_STATUS, 32'h0);
    chk(rdv & 32'h64, 32'h0);
    tend("status");
    wr(`SLTSR_IDX_LINK_EN, 32'h0);
    wr(`SLTSR_IDX_TEST, 32'h0);
    wr(`SLTSR_IDX_COMMA, 32'h1);
    hold <= 1'b1;
    wr(`SLTSR_IDX_LINK_EN, 32'h1);
    repeat (8) @(posedge ref_clk);
    n = 0;
    repeat (8) begin
      @(negedge ref_clk);
      if (lane_out[0] === {1'b1, `SLTSR_K28_1}) n++;
    end
    chk(n, 32'h4);
    wr(`SLTSR_IDX_LINK_EN, 32'h0);
    hold <= 1'b0;
    wr(`SLTSR_IDX_COMMA, 32'h0);
    wr(`SLTSR_IDX_LINK_EN, 32'h1);
    sysref_pulse();
    wr(`SLTSR_IDX_STATUS, 32'he7);
    xfer(1'b0, `SLTSR_IDX_STATUS, 32'h0);
    chk(rdv & 32'he8, 32'h08);
    wr(`SLTSR_IDX_STATUS, 32'h18);
    xfer(1'b0, `SLTSR_IDX_STATUS, 32'h0);
    chk(rdv & 32'h18, 32'h0);
    wr(`SLTSR_IDX_IRQ_STAT, 32'hf);
    n = 0;
    while (lmfc_edge !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    sysref_pulse();
    xfer(1'b0, `SLTSR_IDX_STATUS, 32'h0);
    chk(rdv & 32'h18, 32'h10);
    chk({31'h0, irq}, 32'h0);
    wr(`SLTSR_IDX_IRQ_MASK, 32'h1);
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    wr(`SLTSR_IDX_IRQ_STAT, 32'h1);
    @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    rdc(`SLTSR_IDX_IRQ_MASK);
    tend("sysref");
    test_done();
  end
endmodule
